// ### rtl/etio_top.sv
// Operation
// - software selects rising or falling edges on the trigger input
// - falling selection triggers when the line is pulled to ground
// - rising selection triggers when the line returns high
// - level changes shorter than 30 ms are ignored by the debouncer
// - undriven input reads high through the internal pull-up
// - the trigger output can drive a pulse when configured
// - an output pulse may be emitted when log storage becomes full
// - an accepted trigger edge may start logging
// - post-trigger time zero means logging never stops on a timer
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module etio_top #(
  parameter int unsigned DEBOUNCE_CYC = etio_pkg::DEBOUNCE_CYC,
  parameter int unsigned TICK_CYC     = etio_pkg::TICK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        trig_in,
  input  wire logic        trig_in_driven,
  input  wire logic        storage_full,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             trig_out,
  output logic             log_start,
  output logic             log_stop,
  output logic             logging,
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl;
  logic [3:0]  stat;
  logic [3:0]  mask;
  logic [15:0] post_ms;
  logic [15:0] pulse_ms;
  logic [15:0] post_left;
  logic        pin_level;
  logic        trig_ev;
  logic        full_d;
  logic        full_ev;
  logic        fire;
  logic        busy;
  logic        tick;
  logic        post_end;
  logic [3:0]  events;
  logic        sw_pulse;

  etio_deb_if deb ();

  // pull-up: an undriven pin is seen as high
  assign pin_level = trig_in_driven ? trig_in : 1'b1;

  etio_debounce #(
    .STABLE_CYC (DEBOUNCE_CYC)
  ) u_deb (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_in   (pin_level),
    .deb      (deb)
  );

  //////////////////////////////////////////////////////////////////////
  // edge select; debouncer gives single-cycle pulses
  always_comb begin
    if (!ctrl[etio_pkg::CTRL_IN_EN]) begin
      trig_ev = 1'b0;
    end else if (ctrl[etio_pkg::CTRL_EDGE_RISE]) begin
      trig_ev = deb.rise;
    end else begin
      trig_ev = deb.fall;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      full_d <= 1'b0;
    end else begin
      full_d <= storage_full;
    end
  end
  assign full_ev = storage_full && !full_d;

  //////////////////////////////////////////////////////////////////////
  // output pulse
  assign sw_pulse = wr && (addr == etio_pkg::REG_CTRL) &&
                    wdata[etio_pkg::CTRL_OUT_SW];
  assign fire = sw_pulse ||
                (full_ev && ctrl[etio_pkg::CTRL_OUT_FULL]);

  etio_pulse #(
    .TICK_CYC (TICK_CYC)
  ) u_pulse (
    .core_clk (core_clk),
    .resetn   (resetn),
    .fire     (fire),
    .len_ms   (pulse_ms),
    .busy     (busy),
    .tick     (tick)
  );

  // active low pulse, so a chained input sees a falling edge first
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      trig_out <= 1'b1;
    end else begin
      trig_out <= !busy;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // logging session and post-trigger timer
  assign post_end = logging && (post_ms != 16'h0000) && tick &&
                    (post_left == 16'h0001);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      logging   <= 1'b0;
      log_start <= 1'b0;
      log_stop  <= 1'b0;
      post_left <= '0;
    end else begin
      log_start <= 1'b0;
      log_stop  <= 1'b0;
      if (trig_ev && ctrl[etio_pkg::CTRL_START_EN] && !logging) begin
        logging   <= 1'b1;
        log_start <= 1'b1;
        post_left <= post_ms;
      end else if (logging && wr && (addr == etio_pkg::REG_CTRL) &&
                   wdata[etio_pkg::CTRL_STOP_SW]) begin
        logging  <= 1'b0;
        log_stop <= 1'b1;
      end else if (post_end) begin
        logging  <= 1'b0;
        log_stop <= 1'b1;
      end else if (logging && tick && post_ms != 16'h0000) begin
        post_left <= post_left - 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl <= etio_pkg::CTRL_RESET;
    end else if (wr && addr == etio_pkg::REG_CTRL) begin
      ctrl <= wdata[7:0];
      // self-clearing command bits never stay set
      ctrl[etio_pkg::CTRL_OUT_SW]  <= 1'b0;
      ctrl[etio_pkg::CTRL_STOP_SW] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mask     <= etio_pkg::MASK_RESET;
      post_ms  <= etio_pkg::POST_RESET;
      pulse_ms <= etio_pkg::PULSE_LEN_RESET;
    end else if (wr) begin
      if (addr == etio_pkg::REG_MASK) begin
        mask <= wdata[3:0];
      end
      if (addr == etio_pkg::REG_POST) begin
        post_ms <= wdata;
      end
      if (addr == etio_pkg::REG_LEVEL) begin
        pulse_ms <= wdata;
      end
    end
  end

  assign events = {fire && !busy, post_end, full_ev, trig_ev};

  // set wins over write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stat <= '0;
    end else if (wr && addr == etio_pkg::REG_STAT) begin
      stat <= (stat & ~wdata[3:0]) | events;
    end else begin
      stat <= stat | events;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        etio_pkg::REG_CTRL:  rdata <= {8'h00, ctrl};
        etio_pkg::REG_STAT:  rdata <= {12'h000, stat};
        etio_pkg::REG_MASK:  rdata <= {12'h000, mask};
        etio_pkg::REG_POST:  rdata <= post_ms;
        etio_pkg::REG_LEVEL: rdata <= pulse_ms;
        etio_pkg::REG_STATE: rdata <= {13'h0, logging, busy,
                                       deb.level};
        default:             rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  property p_fall_trig;
    @(posedge core_clk) disable iff (!resetn)
      deb.fall && ctrl[etio_pkg::CTRL_IN_EN] &&
      !ctrl[etio_pkg::CTRL_EDGE_RISE] |=> stat[etio_pkg::EV_TRIG];
  endproperty
  a_fall_trig: assert property (p_fall_trig)
    else $error("falling edge did not trigger");

  property p_rise_trig;
    @(posedge core_clk) disable iff (!resetn)
      deb.rise && ctrl[etio_pkg::CTRL_IN_EN] &&
      ctrl[etio_pkg::CTRL_EDGE_RISE] |=> stat[etio_pkg::EV_TRIG];
  endproperty
  a_rise_trig: assert property (p_rise_trig)
    else $error("rising edge did not trigger");

  property p_wrong_edge;
    @(posedge core_clk) disable iff (!resetn)
      trig_ev |-> (ctrl[etio_pkg::CTRL_EDGE_RISE] ? deb.rise : deb.fall);
  endproperty
  a_wrong_edge: assert property (p_wrong_edge)
    else $error("trigger on opposite edge");

  property p_single;
    @(posedge core_clk) disable iff (!resetn)
      trig_ev |=> !trig_ev;
  endproperty
  a_single: assert property (p_single)
    else $error("more than one trigger per edge");

  property p_pullup;
    @(posedge core_clk) disable iff (!resetn)
      !trig_in_driven |-> pin_level;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("undriven input not high");

  property p_out_pulse;
    @(posedge core_clk) disable iff (!resetn)
      fire && !busy |=> busy ##1 !trig_out;
  endproperty
  a_out_pulse: assert property (p_out_pulse)
    else $error("output pulse not driven");

  property p_full_pulse;
    @(posedge core_clk) disable iff (!resetn)
      full_ev && ctrl[etio_pkg::CTRL_OUT_FULL] |-> fire;
  endproperty
  a_full_pulse: assert property (p_full_pulse)
    else $error("full did not fire output");

  property p_start;
    @(posedge core_clk) disable iff (!resetn)
      trig_ev && ctrl[etio_pkg::CTRL_START_EN] && !logging |=>
        logging && log_start;
  endproperty
  a_start: assert property (p_start)
    else $error("trigger did not start logging");

  property p_infinite;
    @(posedge core_clk) disable iff (!resetn)
      logging && post_ms == 16'h0000 |-> !post_end;
  endproperty
  a_infinite: assert property (p_infinite)
    else $error("timed stop with zero post time");

  // checker-only run length of the raw pin against the debounced level,
  // kept apart from the debouncer's own counter
  logic [31:0] diff_run;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      diff_run <= '0;
    end else if (pin_level == deb.level) begin
      diff_run <= '0;
    end else begin
      diff_run <= diff_run + 32'h0000_0001;
    end
  end

  property p_deb_run;
    @(posedge core_clk) disable iff (!resetn)
      deb.rise || deb.fall |-> diff_run == 32'(DEBOUNCE_CYC);
  endproperty
  a_deb_run: assert property (p_deb_run)
    else $error("debounced edge without a full stable run");

  property p_opposite_quiet;
    @(posedge core_clk) disable iff (!resetn)
      (ctrl[etio_pkg::CTRL_EDGE_RISE] ? deb.fall : deb.rise) |=>
        !log_start;
  endproperty
  a_opposite_quiet: assert property (p_opposite_quiet)
    else $error("opposite edge started logging");

  property p_disabled;
    @(posedge core_clk) disable iff (!resetn)
      !ctrl[etio_pkg::CTRL_IN_EN] |=> !log_start;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled input started logging");

  property p_start_once;
    @(posedge core_clk) disable iff (!resetn)
      log_start |=> !log_start;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("start pulse longer than one cycle");

  property p_start_stat;
    @(posedge core_clk) disable iff (!resetn)
      log_start |-> logging && stat[etio_pkg::EV_TRIG];
  endproperty
  a_start_stat: assert property (p_start_stat)
    else $error("start without trigger status");

  property p_post_stop;
    @(posedge core_clk) disable iff (!resetn)
      post_end |=> !logging && log_stop && stat[etio_pkg::EV_POSTEND];
  endproperty
  a_post_stop: assert property (p_post_stop)
    else $error("post time end did not stop logging");

  property p_zero_post_runs;
    @(posedge core_clk) disable iff (!resetn)
      logging && post_ms == 16'h0000 &&
      !(wr && addr == etio_pkg::REG_CTRL &&
        wdata[etio_pkg::CTRL_STOP_SW]) |=> logging;
  endproperty
  a_zero_post_runs: assert property (p_zero_post_runs)
    else $error("zero post time stopped on its own");

  property p_full_stat;
    @(posedge core_clk) disable iff (!resetn)
      full_ev |=> stat[etio_pkg::EV_FULL];
  endproperty
  a_full_stat: assert property (p_full_stat)
    else $error("storage full not recorded");

  property p_idle_high;
    @(posedge core_clk) disable iff (!resetn)
      !busy |=> trig_out;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("output low without a pulse");
endmodule
`default_nettype wire

// ### rtl/etio_pkg.sv
package etio_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned DEBOUNCE_MS     = 30;
  localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYC        = (CLK_HZ / 1_000_000) * TICK_US;
  // must outlast the input debounce, or a chained unit never sees it
  localparam int unsigned PULSE_MS        = 100;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STAT   = 4'h1;
  localparam logic [3:0] REG_MASK   = 4'h2;
  localparam logic [3:0] REG_POST   = 4'h3;
  localparam logic [3:0] REG_LEVEL  = 4'h4;
  localparam logic [3:0] REG_STATE  = 4'h5;

  localparam int unsigned CTRL_EDGE_RISE = 0;
  localparam int unsigned CTRL_IN_EN     = 1;
  localparam int unsigned CTRL_OUT_FULL  = 2;
  localparam int unsigned CTRL_OUT_SW    = 3;
  localparam int unsigned CTRL_START_EN  = 4;
  localparam int unsigned CTRL_STOP_SW   = 5;

  localparam int unsigned EV_TRIG    = 0;
  localparam int unsigned EV_FULL    = 1;
  localparam int unsigned EV_POSTEND = 2;
  localparam int unsigned EV_PULSE   = 3;
  localparam int unsigned EV_W       = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [15:0] POST_RESET = 16'h0000;
  localparam logic [15:0] PULSE_LEN_RESET = 16'(PULSE_MS);
endpackage

// ### rtl/etio_deb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface etio_deb_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ### rtl/etio_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module etio_debounce #(
  parameter int unsigned STABLE_CYC = etio_pkg::DEBOUNCE_CYC
) (
  input  wire logic  core_clk,
  input  wire logic  resetn,
  input  wire logic  pin_in,
  etio_deb_if.src    deb
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  logic [CW-1:0] cnt;

  // idle level is high, matching the pull-up, so reset yields no edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      deb.level <= 1'b1;
      cnt       <= '0;
      deb.rise  <= 1'b0;
      deb.fall  <= 1'b0;
    end else begin
      deb.rise <= 1'b0;
      deb.fall <= 1'b0;
      if (pin_in == deb.level) begin
        cnt <= '0;
      end else if (cnt == CW'(STABLE_CYC - 1)) begin
        cnt       <= '0;
        deb.level <= pin_in;
        deb.rise  <= pin_in;
        deb.fall  <= !pin_in;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  property p_short_ignored;
    @(posedge core_clk) disable iff (!resetn)
      (deb.level == pin_in) ##1 (deb.level != pin_in) |->
        ##1 $stable(deb.level);
  endproperty
  a_short_ignored: assert property (p_short_ignored)
    else $error("level changed too soon");

  property p_one_edge;
    @(posedge core_clk) disable iff (!resetn)
      deb.rise || deb.fall |-> ##1 !(deb.rise || deb.fall);
  endproperty
  a_one_edge: assert property (p_one_edge)
    else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// ### rtl/etio_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module etio_pulse #(
  parameter int unsigned TICK_CYC = etio_pkg::TICK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        fire,
  input  wire logic [15:0] len_ms,
  output logic             busy,
  output logic             tick
);
  localparam int unsigned TW = $clog2(TICK_CYC + 1);
  logic [TW-1:0] div;
  logic [15:0]   left;

  // one ms enable shared by the pulse and the post-trigger timer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div == TW'(TICK_CYC - 1));
      div  <= (div == TW'(TICK_CYC - 1)) ? '0 : div + TW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      left <= '0;
      busy <= 1'b0;
    end else if (fire && !busy) begin
      left <= (len_ms == 16'h0000) ? 16'h0001 : len_ms;
      busy <= 1'b1;
    end else if (busy && tick) begin
      left <= left - 16'h0001;
      busy <= (left != 16'h0001);
    end
  end
endmodule
`default_nettype wire

// ### sim/etio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module etio_pin_model (
  input  wire logic core_clk,
  output var logic  trig_in,
  output var logic  trig_in_driven,
  output var logic  storage_full
);
  initial begin
    // starts undriven, pin floats opposite to the pull-up level
    trig_in        = 1'b0;
    trig_in_driven = 1'b0;
    storage_full   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic drive(input logic v, input int n);
    @(posedge core_clk);
    trig_in        <= v;
    trig_in_driven <= 1'b1;
    repeat (n) @(posedge core_clk);
  endtask

  // released line floats low, so only the pull-up can make it read high
  task automatic release_pin(input int n);
    @(posedge core_clk);
    trig_in        <= 1'b0;
    trig_in_driven <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic set_full(input logic v);
    @(posedge core_clk);
    storage_full <= v;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DEB = 20;
  localparam int TCK = 5;
  logic        core_clk;
  logic        resetn;
  logic        trig_in;
  logic        trig_in_driven;
  logic        storage_full;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        trig_out;
  logic        log_start;
  logic        log_stop;
  logic        logging;
  logic        irq;
  logic [15:0] v;
  int          n_fail;
  int          check_count;
  int          n_start = 0;
  int          n_stop = 0;
  int          low;

  etio_top #(.DEBOUNCE_CYC(DEB), .TICK_CYC(TCK)) dut (
    .core_clk(core_clk), .resetn(resetn), .trig_in(trig_in),
    .trig_in_driven(trig_in_driven), .storage_full(storage_full),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trig_out(trig_out), .log_start(log_start), .log_stop(log_stop),
    .logging(logging), .irq(irq));

  etio_pin_model src (
    .core_clk(core_clk), .trig_in(trig_in),
    .trig_in_driven(trig_in_driven), .storage_full(storage_full));

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (log_start === 1'b1) n_start <= n_start + 1;
  end

  always @(posedge core_clk) begin
    if (log_stop === 1'b1) n_stop <= n_stop + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd   <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask

  // bounded: low stays 0 when the output never falls
  task automatic measure_pulse(output int n);
    n = 0;
    for (int i = 0; i < 12 && trig_out !== 1'b0; i++) @(negedge core_clk);
    while (trig_out === 1'b0 && n < 40) begin
      n++;
      @(negedge core_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_pullup;
    rd_reg(4'h0, v); chk("ctrl_reset", v, 16'h0000);
    rd_reg(4'h2, v); chk("mask_reset", v, 16'h0000);
    rd_reg(4'h3, v); chk("post_reset", v, 16'h0000);
    rd_reg(4'h4, v); chk("len_reset", v, 16'h0064);
    rd_reg(4'hf, v); chk("unmapped", v, 16'h0000);
    chk("trig_out_idle", {15'h0, trig_out}, 16'h0001);
    wr_reg(4'h0, 16'h0012);
    repeat (2 * DEB) @(posedge core_clk);
    rd_reg(4'h1, v); chk("stat_floating", v, 16'h0000);
    rd_reg(4'h5, v); chk("level_floating", v & 16'h1, 16'h0001);
  endtask

  task automatic t_falling;
    wr_reg(4'h2, 16'h0001);
    // the next call's edge adds one sample: DEB-1 low samples in all
    src.drive(1'b0, DEB - 2);
    src.drive(1'b1, DEB + 10);
    rd_reg(4'h1, v); chk("glitch_ignored", v, 16'h0000);
    src.drive(1'b0, DEB + 10);
    rd_reg(4'h1, v); chk("fall_stat", v, 16'h0001);
    chk("fall_logging", {15'h0, logging}, 16'h0001);
    chk("fall_irq", {15'h0, irq}, 16'h0001);
    wr_reg(4'h2, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk("irq_masked", {15'h0, irq}, 16'h0000);
    wr_reg(4'h1, 16'h0001);
    src.drive(1'b1, DEB + 10);
    rd_reg(4'h1, v); chk("rise_ignored", v, 16'h0000);
    chk("one_start", 16'(n_start), 16'h0001);
  endtask

  task automatic t_rising;
    wr_reg(4'h0, 16'h0033);
    repeat (2) @(posedge core_clk);
    chk("stopped", {15'h0, logging}, 16'h0000);
    chk("sw_stop", 16'(n_stop), 16'h0001);
    src.drive(1'b0, DEB + 10);
    rd_reg(4'h1, v); chk("fall_ignored", v, 16'h0000);
    src.release_pin(DEB + 10);
    rd_reg(4'h1, v); chk("rise_stat", v, 16'h0001);
    chk("two_starts", 16'(n_start), 16'h0002);
    repeat (20 * TCK) @(posedge core_clk);
    chk("post_zero_runs", {15'h0, logging}, 16'h0001);
    rd_reg(4'h5, v); chk("level_logging", v & 16'h5, 16'h0005);
  endtask

  task automatic t_pulse;
    wr_reg(4'h1, 16'h000f);
    wr_reg(4'h4, 16'h0002);
    wr_reg(4'h0, 16'h0004);
    src.set_full(1'b1);
    measure_pulse(low);
    chk("full_pulse", {15'h0, low >= TCK && low <= 2 * TCK + 1}, 16'h1);
    rd_reg(4'h1, v); chk("full_stat", v, 16'h000a);
    wr_reg(4'h1, 16'h000f);
    wr_reg(4'h0, 16'h0008);
    measure_pulse(low);
    chk("sw_pulse", {15'h0, low >= TCK && low <= 2 * TCK + 1}, 16'h1);
    src.set_full(1'b0);
    src.set_full(1'b1);
    measure_pulse(low);
    chk("full_no_pulse", 16'(low), 16'h0000);
  endtask

  task automatic t_post;
    wr_reg(4'h1, 16'h000f);
    wr_reg(4'h3, 16'h0003);
    wr_reg(4'h0, 16'h0033);
    repeat (2) @(posedge core_clk);
    chk("sw_stop_again", 16'(n_stop), 16'h0002);
    src.drive(1'b0, DEB + 10);
    src.release_pin(DEB + 2);
    chk("post_running", {15'h0, logging}, 16'h0001);
    repeat (4 * TCK) @(posedge core_clk);
    chk("post_ended", {15'h0, logging}, 16'h0000);
    chk("post_stop", 16'(n_stop), 16'h0003);
    rd_reg(4'h1, v); chk("post_stat", v, 16'h0005);
  endtask

  task automatic t_chain;
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h4, 16'h0006);
    wr_reg(4'h1, 16'h000f);
    // own output looped back as an upstream logger; pre-trigger history
    // is the downstream host's setting, nothing here holds it
    wr_reg(4'h0, 16'h001a);
    repeat (2 * DEB) src.drive(trig_out, 0);
    chk("chain_logging", {15'h0, logging}, 16'h0001);
    chk("chain_starts", 16'(n_start), 16'h0004);
    rd_reg(4'h1, v); chk("chain_stat", v, 16'h0009);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk    = 1'b0;
    resetn      = 1'b0;
    addr        = 4'h0;
    wdata       = 16'h0000;
    wr          = 1'b0;
    rd          = 1'b0;
    n_fail      = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset_pullup();
    t_falling();
    t_rising();
    t_pulse();
    t_post();
    t_chain();
    print_verdict();
  end
endmodule
`default_nettype wire
